// ==== shared/mpwm_pkg.sv ====
/*
 * Constants and types for the six-channel pulse-width generator.
 * Assumes byte-wide register access on a plain strobe port.
 */
package mpwm_pkg;
    localparam int NUM_CH = 6;
    localparam logic [10:0] ADDR_ENABLE = 11'h780;
    localparam logic [10:0] ADDR_CLKDIV = 11'h781;
    localparam logic [10:0] ADDR_MODE = 11'h782;
    localparam logic [10:0] ADDR_POLARITY = 11'h785;
    localparam logic [10:0] ADDR_CMP_BASE = 11'h794;
    localparam logic [10:0] ADDR_PNUM_LO = 11'h7ac;
    localparam logic [10:0] ADDR_PNUM_HI = 11'h7ad;
    localparam logic [10:0] ADDR_MASK_MAIN = 11'h7b0;
    localparam logic [10:0] ADDR_FLAG_MAIN = 11'h7b1;
    localparam logic [10:0] ADDR_MASK_QUEUE = 11'h7b2;
    localparam logic [10:0] ADDR_FLAG_QUEUE = 11'h7b3;
    localparam logic [10:0] ADDR_ALT_BASE = 11'h7c4;
    localparam logic [10:0] ADDR_ENTRY0 = 11'h7c8;
    localparam logic [10:0] ADDR_ENTRY3 = 11'h7cb;
    localparam logic [10:0] ADDR_TRIG_LVL = 11'h7cc;
    localparam logic [10:0] ADDR_QSTATUS = 11'h7cd;
    localparam logic [10:0] ADDR_QFLUSH = 11'h7ce;
    localparam logic [3:0] MODE_CONT = 4'h0;
    localparam logic [3:0] MODE_COUNT = 4'h1;
    localparam logic [3:0] MODE_IR = 4'h3;
    localparam logic [3:0] MODE_FIFO = 4'h7;
    localparam logic [3:0] MODE_DMA = 4'hf;
    localparam int FIFO_BYTES = 8;
    localparam int FLAG_GROUP_BIT = 0;
    localparam int FLAG_FRAME_BASE = 2;
    localparam int STAT_EMPTY_BIT = 4;
    localparam int STAT_FULL_BIT = 5;
    localparam int ELEM_CARRIER_BIT = 15;
    localparam int ELEM_ALT_BIT = 14;
    localparam logic [7:0] ALT_CMP_RESET = 8'h55;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef struct packed {
        logic [10:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mpwm_bus_t;

    typedef struct packed {
        logic carrier;
        logic alt;
        logic [13:0] count;
    } mpwm_elem_t;
endpackage

// ==== src/mpwm_top.sv ====
/*
 * Six-channel pulse-width generator with counting, repeating infrared and
 * element-queue modes on channel zero.
 * Assumes a byte-wide register port and a DMA that pushes bytes on dma_*.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps

//Function
//- Polarity bit set inverts output: low while counting, high in remainder.
//- Mode register picks channel zero mode; others always continuous.
//- Continuous mode runs frames until enable clears; output low at once.
//- Continuous mode loads new compare and period at next frame start.
//- Each frame end sets cycle-done flag; masked interrupt; write one clears.
//- Mode 0001 is counting: one pulse group then stop.
//- Pulse group length comes from 16-bit pulse-number register.
//- Counting group end clears enable, sets group-done flag, masked interrupt.
//- Mode 0011 repeats groups forever, flags each frame and group.
//- Repeating mode loads compare, period, pulse number at next group.
//- Switching repeating mode to counting finishes group then disables.
//- Clearing enable in repeating mode forces output low immediately.
//- Mode 0111 sequences channel zero from 16-bit queue elements.
//- Element: bits 13:0 count, bit 14 set select, bit 15 carrier.
//- Bit 14 zero uses primary set; one uses alternate set.
//- Entry window accepts byte, half-word and word loading.
//- Eight-byte queue; status shows byte count, empty, full.
//- Enabled channel zero plays elements in order; appends allowed.
//- Queue empty after last element clears enable, sets stop flag.
//- Writing one to flush bit empties the queue.
//- Mode 1111 lets DMA fill the queue.
//- DMA enable in DMA mode sets channel zero enable itself.
//- Output high until counter reaches compare, low until period.
//- Counters tick at system clock divided by one plus divider.
//- Queue-count flag set in mode 0111 when byte count below trigger level.
module mpwm_top #(
    parameter int CH = mpwm_pkg::NUM_CH
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire mpwm_pkg::mpwm_bus_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic dma_enable_i,
    input wire logic dma_valid_i,
    input wire logic [7:0] dma_data_i,
    output logic dma_ready_o,
    output logic [CH-1:0] pwm_o,
    output logic irq_o
);
    import mpwm_pkg::*;

    // Flag bits 2 to 7 leave room for six channels only
    if (CH < 1 || CH > 6) begin : g_bad_ch
        $error("CH must be 1 to 6");
    end

    logic [7:0] enable, next_enable;
    logic [7:0] clkdiv, next_clkdiv;
    logic [7:0] mode, next_mode;
    logic [7:0] polarity, next_polarity;
    logic [7:0] cmp_reg [CH*4];
    logic [7:0] next_cmp_reg [CH*4];
    logic [15:0] pnum, next_pnum;
    logic [7:0] alt_reg [4];
    logic [7:0] next_alt_reg [4];
    logic [7:0] mask_main, next_mask_main;
    logic [7:0] flag_main, next_flag_main;
    logic mask_q, next_mask_q;
    logic [1:0] flag_q, next_flag_q;
    logic [3:0] trig, next_trig;
    logic [7:0] rdata, next_rdata;
    logic [7:0] fifo [FIFO_BYTES];
    logic [7:0] next_fifo [FIFO_BYTES];
    logic [3:0] fcount, next_fcount;
    logic [2:0] rptr, next_rptr;
    logic [2:0] wptr, next_wptr;
    logic [7:0] prescale, next_prescale;
    logic [15:0] cnt [CH];
    logic [15:0] next_cnt [CH];
    logic [15:0] cur_cmp [CH];
    logic [15:0] next_cur_cmp [CH];
    logic [15:0] cur_per [CH];
    logic [15:0] next_cur_per [CH];
    logic [15:0] pcount, next_pcount;
    logic [15:0] cur_pnum, next_cur_pnum;
    logic carrier, next_carrier;
    logic loaded, next_loaded;
    logic [CH-1:0] run, next_run;
    logic [CH-1:0] pwm, next_pwm;
    logic irq, next_irq;
    logic dma_en_d, next_dma_en_d;

    logic tick;
    logic fifo_mode;
    logic [CH-1:0] frame_end;
    logic group_end;
    logic [7:0] din;
    logic push;
    logic pop;
    logic [3:0] fcount_pop;

    always_comb begin
        fifo_mode = (mode[3:0] == MODE_FIFO) || (mode[3:0] == MODE_DMA);
        tick = (prescale == clkdiv);
        din = bus_i.wdata;
        push = 1'b0;
        if (bus_i.wr && bus_i.addr >= ADDR_ENTRY0 && bus_i.addr <= ADDR_ENTRY3) begin
            push = (fcount < 4'(FIFO_BYTES));
        end else if (mode[3:0] == MODE_DMA && dma_valid_i && !bus_i.wr
            && fcount < 4'(FIFO_BYTES)) begin
            // Same terms as dma_ready_o, so a held byte is never taken twice
            push = 1'b1;
            din = dma_data_i;
        end
    end

    always_comb begin
        next_enable = enable;
        next_clkdiv = clkdiv;
        next_mode = mode;
        next_polarity = polarity;
        next_cmp_reg = cmp_reg;
        next_pnum = pnum;
        next_alt_reg = alt_reg;
        next_mask_main = mask_main;
        next_flag_main = flag_main;
        next_mask_q = mask_q;
        next_flag_q = flag_q;
        next_trig = trig;
        next_rdata = BYTE_ZERO;
        next_fifo = fifo;
        next_fcount = fcount;
        next_rptr = rptr;
        next_wptr = wptr;
        next_prescale = tick ? BYTE_ZERO : prescale + 8'h01;
        next_cnt = cnt;
        next_cur_cmp = cur_cmp;
        next_cur_per = cur_per;
        next_pcount = pcount;
        next_cur_pnum = cur_pnum;
        next_carrier = carrier;
        next_loaded = loaded;
        next_run = run;
        next_pwm = pwm;
        next_dma_en_d = dma_enable_i;
        frame_end = '0;
        group_end = 1'b0;
        pop = 1'b0;
        fcount_pop = fcount;

        // Register writes first; hardware events below win over flag clears, but a flush wins over push and pop
        if (bus_i.wr) begin
            if (bus_i.addr == ADDR_ENABLE) begin
                next_enable = bus_i.wdata;
            end else if (bus_i.addr == ADDR_CLKDIV) begin
                next_clkdiv = bus_i.wdata;
            end else if (bus_i.addr == ADDR_MODE) begin
                next_mode = bus_i.wdata;
            end else if (bus_i.addr == ADDR_POLARITY) begin
                next_polarity = bus_i.wdata;
            end else if (bus_i.addr >= ADDR_CMP_BASE && bus_i.addr < ADDR_CMP_BASE + 11'(CH*4)) begin
                next_cmp_reg[5'(bus_i.addr - ADDR_CMP_BASE)] = bus_i.wdata;
            end else if (bus_i.addr == ADDR_PNUM_LO) begin
                next_pnum[7:0] = bus_i.wdata;
            end else if (bus_i.addr == ADDR_PNUM_HI) begin
                next_pnum[15:8] = bus_i.wdata;
            end else if (bus_i.addr == ADDR_MASK_MAIN) begin
                next_mask_main = bus_i.wdata;
            end else if (bus_i.addr == ADDR_FLAG_MAIN) begin
                next_flag_main = flag_main & ~bus_i.wdata;
            end else if (bus_i.addr == ADDR_MASK_QUEUE) begin
                next_mask_q = bus_i.wdata[0];
            end else if (bus_i.addr == ADDR_FLAG_QUEUE) begin
                next_flag_q = flag_q & ~bus_i.wdata[1:0];
            end else if (bus_i.addr >= ADDR_ALT_BASE && bus_i.addr < ADDR_ENTRY0) begin
                next_alt_reg[2'(bus_i.addr - ADDR_ALT_BASE)] = bus_i.wdata;
            end else if (bus_i.addr == ADDR_TRIG_LVL) begin
                next_trig = bus_i.wdata[3:0];
            end else if (bus_i.addr == ADDR_QFLUSH && bus_i.wdata[0]) begin
                next_rptr = '0;
                next_wptr = '0;
                next_fcount = '0;
            end
        end
        if (bus_i.rd) begin
            if (bus_i.addr == ADDR_ENABLE) begin
                next_rdata = enable;
            end else if (bus_i.addr == ADDR_CLKDIV) begin
                next_rdata = clkdiv;
            end else if (bus_i.addr == ADDR_MODE) begin
                next_rdata = mode;
            end else if (bus_i.addr == ADDR_POLARITY) begin
                next_rdata = polarity;
            end else if (bus_i.addr >= ADDR_CMP_BASE && bus_i.addr < ADDR_CMP_BASE + 11'(CH*4)) begin
                next_rdata = cmp_reg[5'(bus_i.addr - ADDR_CMP_BASE)];
            end else if (bus_i.addr == ADDR_PNUM_LO) begin
                next_rdata = pnum[7:0];
            end else if (bus_i.addr == ADDR_PNUM_HI) begin
                next_rdata = pnum[15:8];
            end else if (bus_i.addr == ADDR_MASK_MAIN) begin
                next_rdata = mask_main;
            end else if (bus_i.addr == ADDR_FLAG_MAIN) begin
                next_rdata = flag_main;
            end else if (bus_i.addr == ADDR_MASK_QUEUE) begin
                next_rdata = {7'h00, mask_q};
            end else if (bus_i.addr == ADDR_FLAG_QUEUE) begin
                next_rdata = {6'h00, flag_q};
            end else if (bus_i.addr >= ADDR_ALT_BASE && bus_i.addr < ADDR_ENTRY0) begin
                next_rdata = alt_reg[2'(bus_i.addr - ADDR_ALT_BASE)];
            end else if (bus_i.addr == ADDR_TRIG_LVL) begin
                next_rdata = {4'h0, trig};
            end else if (bus_i.addr == ADDR_QSTATUS) begin
                next_rdata = {2'b00, fcount == 4'(FIFO_BYTES), fcount == 4'h0, fcount};
            end
        end

        if (mode[3:0] == MODE_DMA && dma_enable_i && !dma_en_d) begin
            next_enable[0] = 1'b1;
        end

        // Channel counters
        for (int i = 0; i < CH; i++) begin
            if (!enable[i]) begin
                next_run[i] = 1'b0;
                next_cnt[i] = '0;
                next_pwm[i] = 1'b0;
                if (i == 0) begin
                    next_loaded = 1'b0;
                end
            end else if (tick) begin
                if (!run[i]) begin
                    next_run[i] = 1'b1;
                    next_cnt[i] = '0;
                    if (i == 0 && fifo_mode) begin
                        next_loaded = 1'b0;
                    end else begin
                        next_cur_cmp[i] = {cmp_reg[i*4+1], cmp_reg[i*4]};
                        next_cur_per[i] = {cmp_reg[i*4+3], cmp_reg[i*4+2]};
                        if (i == 0) begin
                            next_cur_pnum = pnum;
                            next_pcount = '0;
                            next_carrier = 1'b1;
                            next_loaded = 1'b1;
                        end
                    end
                end else if (cnt[i] + 16'h0001 >= cur_per[i]) begin
                    next_cnt[i] = '0;
                    frame_end[i] = 1'b1;
                    if (i != 0 || mode[3:0] == MODE_CONT) begin
                        next_cur_cmp[i] = {cmp_reg[i*4+1], cmp_reg[i*4]};
                        next_cur_per[i] = {cmp_reg[i*4+3], cmp_reg[i*4+2]};
                    end
                end else begin
                    next_cnt[i] = cnt[i] + 16'h0001;
                end
                // Frame start shows the counting level at once; queue start sets it below
                if (run[i] || i != 0 || !fifo_mode) begin
                    next_pwm[i] = ((next_cnt[i] < next_cur_cmp[i]) ^ polarity[i])
                        & (i != 0 || !fifo_mode || next_carrier);
                end
            end
        end

        // Channel zero group sequencing
        if (enable[0] && frame_end[0] && mode[3:0] != MODE_CONT) begin
            next_pcount = pcount + 16'h0001;
            if (pcount + 16'h0001 >= cur_pnum) begin
                group_end = 1'b1;
                next_pcount = '0;
                if (mode[3:0] == MODE_COUNT) begin
                    next_enable[0] = 1'b0;
                    next_pwm[0] = 1'b0;
                end else if (mode[3:0] == MODE_IR) begin
                    next_cur_cmp[0] = {cmp_reg[1], cmp_reg[0]};
                    next_cur_per[0] = {cmp_reg[3], cmp_reg[2]};
                    next_cur_pnum = pnum;
                    next_pwm[0] = polarity[0] ^ (next_cur_cmp[0] != 16'h0000);
                end else begin
                    next_loaded = 1'b0;
                    next_run[0] = 1'b0;
                end
            end
        end

        // Element fetch: two bytes, low byte first; a group end fetches at once
        if (enable[0] && fifo_mode && tick && ((!run[0] && !loaded) || group_end)) begin
            if (fcount >= 4'h2) begin
                pop = 1'b1;
                next_cur_pnum = {2'b00, fifo[rptr + 3'd1][5:0], fifo[rptr]};
                next_carrier = fifo[rptr + 3'd1][7];
                next_cur_cmp[0] = fifo[rptr + 3'd1][6] ? {alt_reg[1], alt_reg[0]}
                    : {cmp_reg[1], cmp_reg[0]};
                next_cur_per[0] = fifo[rptr + 3'd1][6] ? {alt_reg[3], alt_reg[2]}
                    : {cmp_reg[3], cmp_reg[2]};
                next_pcount = '0;
                next_loaded = 1'b1;
                next_run[0] = 1'b1;
                next_pwm[0] = fifo[rptr + 3'd1][7] & (polarity[0] ^ (next_cur_cmp[0] != 16'h0000));
            end else begin
                // Half an element waits, idle, for its second byte
                next_run[0] = 1'b0;
                next_pwm[0] = 1'b0;
                if (fcount == 4'h0) begin
                    next_enable[0] = 1'b0;
                    next_flag_q[0] = 1'b1;
                end
            end
        end

        if (!(bus_i.wr && bus_i.addr == ADDR_QFLUSH && bus_i.wdata[0])) begin
            if (pop) begin
                next_rptr = rptr + 3'd2;
                fcount_pop = fcount - 4'h2;
            end
            if (push) begin
                next_fifo[wptr] = din;
                next_wptr = wptr + 3'd1;
            end
            next_fcount = fcount_pop + (push ? 4'h1 : 4'h0);
        end
        if (mode[3:0] == MODE_FIFO && fcount < trig) begin
            next_flag_q[1] = 1'b1;
        end

        for (int i = 0; i < CH; i++) begin
            if (frame_end[i]) begin
                next_flag_main[FLAG_FRAME_BASE + i] = 1'b1;
            end
        end
        if (group_end && (mode[3:0] == MODE_COUNT || mode[3:0] == MODE_IR)) begin
            next_flag_main[FLAG_GROUP_BIT] = 1'b1;
        end
        next_irq = |(next_flag_main & mask_main) | (next_flag_q[0] & mask_q)
            | (next_flag_q[1] & mask_q);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            enable <= BYTE_ZERO;
            clkdiv <= BYTE_ZERO;
            mode <= BYTE_ZERO;
            polarity <= BYTE_ZERO;
            for (int k = 0; k < CH*4; k++) begin
                cmp_reg[k] <= BYTE_ZERO;
            end
            pnum <= '0;
            alt_reg[0] <= ALT_CMP_RESET;
            alt_reg[1] <= ALT_CMP_RESET;
            alt_reg[2] <= BYTE_ZERO;
            alt_reg[3] <= BYTE_ZERO;
            mask_main <= BYTE_ZERO;
            flag_main <= BYTE_ZERO;
            mask_q <= 1'b0;
            flag_q <= '0;
            trig <= '0;
            rdata <= BYTE_ZERO;
            for (int k = 0; k < FIFO_BYTES; k++) begin
                fifo[k] <= BYTE_ZERO;
            end
            fcount <= '0;
            rptr <= '0;
            wptr <= '0;
            prescale <= BYTE_ZERO;
            for (int k = 0; k < CH; k++) begin
                cnt[k] <= '0;
                cur_cmp[k] <= '0;
                cur_per[k] <= '0;
            end
            pcount <= '0;
            cur_pnum <= '0;
            carrier <= 1'b0;
            loaded <= 1'b0;
            run <= '0;
            pwm <= '0;
            irq <= 1'b0;
            dma_en_d <= 1'b0;
        end else begin
            enable <= next_enable;
            clkdiv <= next_clkdiv;
            mode <= next_mode;
            polarity <= next_polarity;
            cmp_reg <= next_cmp_reg;
            pnum <= next_pnum;
            alt_reg <= next_alt_reg;
            mask_main <= next_mask_main;
            flag_main <= next_flag_main;
            mask_q <= next_mask_q;
            flag_q <= next_flag_q;
            trig <= next_trig;
            rdata <= next_rdata;
            fifo <= next_fifo;
            fcount <= next_fcount;
            rptr <= next_rptr;
            wptr <= next_wptr;
            prescale <= next_prescale;
            cnt <= next_cnt;
            cur_cmp <= next_cur_cmp;
            cur_per <= next_cur_per;
            pcount <= next_pcount;
            cur_pnum <= next_cur_pnum;
            carrier <= next_carrier;
            loaded <= next_loaded;
            run <= next_run;
            pwm <= next_pwm;
            irq <= next_irq;
            dma_en_d <= next_dma_en_d;
        end
    end

    assign rdata_o = rdata;
    assign pwm_o = pwm;
    assign irq_o = irq;
    assign dma_ready_o = (fcount < 4'(FIFO_BYTES)) && !bus_i.wr;

    property p_disable_low;
        @(posedge clock_i) disable iff (rst_i)
        !enable[0] |=> !pwm[0];
    endproperty
    a_disable_low: assert property (p_disable_low) else $error("output not low when off");

    property p_count_stop;
        @(posedge clock_i) disable iff (rst_i)
        (group_end && mode[3:0] == MODE_COUNT) |=> !enable[0] && flag_main[0];
    endproperty
    a_count_stop: assert property (p_count_stop) else $error("counting group did not stop");

    property p_frame_flag;
        @(posedge clock_i) disable iff (rst_i)
        frame_end[0] |=> flag_main[FLAG_FRAME_BASE];
    endproperty
    a_frame_flag: assert property (p_frame_flag) else $error("frame flag missing");

    property p_full_drop;
        @(posedge clock_i) disable iff (rst_i)
        (fcount == 4'(FIFO_BYTES) && !pop && !(bus_i.wr && bus_i.addr == ADDR_QFLUSH))
            |=> fcount == 4'(FIFO_BYTES);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full queue changed");

    property p_flush;
        @(posedge clock_i) disable iff (rst_i)
        (bus_i.wr && bus_i.addr == ADDR_QFLUSH && bus_i.wdata[0]) |=> fcount == 4'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left data");

    property p_fifo_stop;
        @(posedge clock_i) disable iff (rst_i)
        (enable[0] && fifo_mode && tick && ((!run[0] && !loaded) || group_end)
            && fcount == 4'h0)
            |=> !enable[0] && flag_q[0];
    endproperty
    a_fifo_stop: assert property (p_fifo_stop) else $error("empty queue did not stop");

    property p_dma_start;
        @(posedge clock_i) disable iff (rst_i)
        (mode[3:0] == MODE_DMA && $rose(dma_enable_i)) ##1 1'b1 |-> enable[0];
    endproperty
    a_dma_start: assert property (p_dma_start) else $error("dma did not enable");

    property p_prescale;
        @(posedge clock_i) disable iff (rst_i)
        tick |=> prescale == 8'h00;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler did not wrap");

    c_count_group: cover property (@(posedge clock_i) disable iff (rst_i)
        group_end && mode[3:0] == MODE_COUNT);
    c_ir_group: cover property (@(posedge clock_i) disable iff (rst_i)
        group_end && mode[3:0] == MODE_IR);
    c_fifo_pop: cover property (@(posedge clock_i) disable iff (rst_i) pop);
endmodule

// ==== verification/mpwm_load.sv ====
/*
 * Load on channel zero of the pulse generator: counts clocks spent high.
 * Assumes the bench clears the count before each burst.
 */
`timescale 1ns/10ps
module mpwm_load (
    input wire logic clock_i,
    input wire logic clear_i,
    input wire logic level_i,
    output logic [15:0] high_count_o
);
    // Purely passive, so it can never mask a stuck output
    always_ff @(posedge clock_i) begin
        if (clear_i) begin
            high_count_o <= 16'h0000;
        end else if (level_i) begin
            high_count_o <= high_count_o + 16'h0001;
        end
    end
endmodule

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the pulse generator, with an integer model.
 * Assumes the byte register port and the load model on channel zero.
 */
`timescale 1ns/10ps
module tb_top;
    import mpwm_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic dma_enable_i = 1'b0;
    logic dma_valid_i = 1'b0;
    logic ld_clr = 1'b1;
    logic [7:0] dma_data_i = 8'h00;
    logic [7:0] rdata_o;
    logic [7:0] rv;
    mpwm_bus_t bus_i = '0;
    logic dma_ready_o;
    logic irq_o;
    logic [5:0] pwm_o;
    logic [15:0] hc;
    int bad_count = 0;
    int n_tests = 0;
    int c, p, n;
    logic [7:0] q[8] = '{8'h02, 8'h80, 8'h03, 8'hc0, 8'h02, 8'h00, 8'h01, 8'h80};
    mpwm_top DUT (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .dma_enable_i(dma_enable_i), .dma_valid_i(dma_valid_i), .dma_data_i(dma_data_i),
        .dma_ready_o(dma_ready_o), .pwm_o(pwm_o), .irq_o(irq_o));
    mpwm_load LOAD (.clock_i(clock_i), .clear_i(ld_clr), .level_i(pwm_o[0]), .high_count_o(hc));
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    task results;
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_i.addr <= a;
        bus_i.wdata <= d;
        bus_i.wr <= 1'b1;
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
    endtask
    task w16(input logic [10:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 11'h001, v[15:8]);
    endtask
    task rd(input logic [10:0] a);
        @(posedge clock_i);
        bus_i.addr <= a;
        bus_i.rd <= 1'b1;
        @(posedge clock_i);
        bus_i.rd <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task chkr(input logic [10:0] a, input logic [7:0] e);
        rd(a);
        cmp({8'h00, rv}, {8'h00, e});
    endtask
    // Starts a burst, waits for the self-clear of enable, checks high time;
    // a nonzero hold lets a repeating run go on, then stops it by counting
    task go(input bit by_dma, input int hold, input logic [15:0] e);
        int i;
        @(posedge clock_i) ld_clr <= 1'b1;
        @(posedge clock_i) ld_clr <= 1'b0;
        if (by_dma) begin
            dma_enable_i <= 1'b1;
        end else begin
            wr(ADDR_ENABLE, 8'h01);
        end
        if (hold > 0) begin
            repeat (hold) @(posedge clock_i);
            wr(ADDR_MODE, {4'h0, MODE_COUNT});
        end
        i = 0;
        rd(ADDR_ENABLE);
        while (rv[0] !== 1'b0 && i < 500) begin
            rd(ADDR_ENABLE);
            i++;
        end
        if (i == 500) begin
            bad_count++;
        end
        repeat (3) @(posedge clock_i);
        if (hold > 0) begin
            cmp(hc % e, 16'h0000);
            cmp({15'h0000, hc > 2 * e}, 16'h0001);
        end else begin
            cmp(hc, e);
        end
    endtask
    initial begin
        #500000;
        bad_count++;
        results();
    end
    initial begin
        void'($urandom(95964));
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        chkr(ADDR_ALT_BASE, ALT_CMP_RESET);
        chkr(ADDR_QSTATUS, 8'h10);
        chkr(11'h7ff, 8'h00);
        w16(ADDR_CMP_BASE, 16'h0002);
        w16(ADDR_CMP_BASE + 11'h002, 16'h0004);
        wr(ADDR_ENABLE, 8'h3f);
        repeat (20) @(posedge clock_i);
        wr(ADDR_ENABLE, 8'h00);
        @(posedge clock_i) #1 cmp({10'h000, pwm_o}, 16'h0000);
        chkr(ADDR_FLAG_MAIN, 8'hfc);
        wr(ADDR_FLAG_MAIN, 8'hff);
        wr(ADDR_MASK_MAIN, 8'h01);
        for (int k = 0; k < 2; k++) begin
            c = $urandom_range(3, 1);
            p = c + $urandom_range(3, 1);
            n = $urandom_range(3, 1);
            wr(ADDR_MODE, {4'h0, MODE_COUNT});
            wr(ADDR_POLARITY, 8'(k));
            w16(ADDR_CMP_BASE, 16'(c));
            w16(ADDR_CMP_BASE + 11'h002, 16'(p));
            w16(ADDR_PNUM_LO, 16'(n));
            go(1'b0, 0, 16'(k ? n * (p - c) : n * c));
            cmp({15'h0000, irq_o}, 16'h0001);
            chkr(ADDR_FLAG_MAIN, 8'h05);
            wr(ADDR_FLAG_MAIN, 8'h05);
            chkr(ADDR_FLAG_MAIN, 8'h00);
            cmp({15'h0000, irq_o}, 16'h0000);
        end
        wr(ADDR_MODE, {4'h0, MODE_FIFO});
        wr(ADDR_POLARITY, 8'h00);
        w16(ADDR_CMP_BASE, 16'h0002);
        w16(ADDR_CMP_BASE + 11'h002, 16'h0004);
        w16(ADDR_ALT_BASE, 16'h0001);
        w16(ADDR_ALT_BASE + 11'h002, 16'h0003);
        w16(ADDR_ENTRY0, 16'h8005);
        wr(ADDR_QFLUSH, 8'h01);
        chkr(ADDR_QSTATUS, 8'h10);
        foreach (q[i]) wr(ADDR_ENTRY0 + 11'(i % 4), q[i]);
        chkr(ADDR_QSTATUS, 8'h28);
        wr(ADDR_ENTRY0, 8'h77);
        chkr(ADDR_QSTATUS, 8'h28);
        wr(ADDR_MASK_QUEUE, 8'h01);
        wr(ADDR_TRIG_LVL, 8'h02);
        go(1'b0, 0, 16'h0009);
        chkr(ADDR_FLAG_QUEUE, 8'h03);
        cmp({15'h0000, irq_o}, 16'h0001);
        wr(ADDR_FLAG_QUEUE, 8'h03);
        wr(ADDR_FLAG_MAIN, 8'hff);
        chkr(ADDR_QSTATUS, 8'h10);
        wr(ADDR_MODE, {4'h0, MODE_DMA});
        @(posedge clock_i);
        dma_valid_i <= 1'b1;
        dma_data_i <= 8'h03;
        do @(posedge clock_i); while (dma_ready_o !== 1'b1);
        dma_data_i <= 8'h80;
        do @(posedge clock_i); while (dma_ready_o !== 1'b1);
        dma_valid_i <= 1'b0;
        go(1'b1, 0, 16'h0006);
        wr(ADDR_FLAG_MAIN, 8'hff);
        wr(ADDR_CLKDIV, 8'h01);
        wr(ADDR_MODE, {4'h0, MODE_IR});
        w16(ADDR_CMP_BASE, 16'h0001);
        w16(ADDR_CMP_BASE + 11'h002, 16'h0003);
        w16(ADDR_PNUM_LO, 16'h0002);
        go(1'b0, 40, 16'h0004);
        chkr(ADDR_FLAG_MAIN, 8'h05);
        results();
    end
endmodule
